// ==== src/plos_defines.vh ====
// Purpose: constants shared by the synthesizer output stage files
// Assumes: mclk stands in for the vco sampling clock
// Notes: definitions only
`ifndef PLOS_DEFINES_VH
`define PLOS_DEFINES_VH

`define PLOS_NUM_OUT      4
`define PLOS_NUM_TAP      8
`define PLOS_TAP_W        3
`define PLOS_DIV_W        7
`define PLOS_DLY_W        3
`define PLOS_FRAC_W       24
`define PLOS_FBI_W        8
`define PLOS_RING_W       5
`define PLOS_HALF_TAP     3'h4
`define PLOS_RING_LAST    5'h1F
`define PLOS_TAP_LAST     3'h7
// taps reset to the step before ring zero, so no cut high after reset
`define PLOS_TAP_RESET    8'hF0
`define PLOS_DIV_ONE      7'h01
`define PLOS_DIV_ZERO     7'h00
`define PLOS_CNT_ZERO     7'h00
`define PLOS_DLY_ZERO     3'h0
`define PLOS_FRAC_ZERO    24'h00_0000
`define PLOS_FBI_ZERO     8'h00
`define PLOS_FBI_ONE      8'h01

`define PLOS_ST_STOP      2'h0
`define PLOS_ST_DELAY     2'h1
`define PLOS_ST_RUN       2'h2

`endif

// ==== src/plos_out_channel.v ====
// Purpose: one output channel: tap select, post-divider, delayed release
// Assumes: taps and vco/4 tick come from the same clock domain
// Notes: config is shadowed while stopped only
`timescale 1ns/1ps
`default_nettype none
`include "plos_defines.vh"

module plos_out_channel (
  input  wire                          mclk,
  input  wire                          sys_rst,
  input  wire [`PLOS_NUM_TAP-1:0]      taps,
  input  wire                          quarterTick,
  input  wire [`PLOS_TAP_W-1:0]        phaseSel,
  input  wire [`PLOS_DIV_W-1:0]        divRatio,
  input  wire [`PLOS_DLY_W-1:0]        startDelay,
  input  wire                          forceZero,
  input  wire                          runReq,
  output reg                           clkOut,
  output wire                          running
);

  reg  [1:0]               state;
  reg  [1:0]               next_state;
  reg  [`PLOS_TAP_W-1:0]   selHeld;
  reg  [`PLOS_DIV_W-1:0]   divHeld;
  reg  [`PLOS_DLY_W-1:0]   dlyHeld;
  reg  [`PLOS_DLY_W-1:0]   dlyCnt;
  reg  [`PLOS_DIV_W-1:0]   edgeCnt;
  reg                      tapPrev;
  wire                     tapNow;
  wire                     tapRise;
  wire                     wantRun;
  wire                     next_clkOut;

  assign tapNow  = taps[selHeld];
  assign tapRise = tapNow & ~tapPrev;
  assign wantRun = runReq & ~forceZero;
  assign running = (state == `PLOS_ST_RUN);

  // high only on the first tap period of each divided cycle
  assign next_clkOut = (next_state == `PLOS_ST_RUN) & tapNow &
                       ((state != `PLOS_ST_RUN) ? tapRise :
                        tapRise ? (edgeCnt == divHeld - `PLOS_DIV_ONE) :
                        (edgeCnt == `PLOS_CNT_ZERO));

  always @*
  begin
    next_state = state;
    case (state)
      `PLOS_ST_STOP:
        if (wantRun & ~clkOut)
          next_state = `PLOS_ST_DELAY;
      `PLOS_ST_DELAY:
        if (~wantRun)
          next_state = `PLOS_ST_STOP;
        else if (dlyCnt == dlyHeld && tapRise)
          next_state = `PLOS_ST_RUN;
      `PLOS_ST_RUN:
        // stop waits for a low output, no runt high pulse
        if (~wantRun & ~clkOut & ~tapRise)
          next_state = `PLOS_ST_STOP;
      default:
        next_state = `PLOS_ST_STOP;
    endcase
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state   <= `PLOS_ST_STOP;
      selHeld <= {`PLOS_TAP_W{1'b0}};
      divHeld <= `PLOS_DIV_ONE;
      dlyHeld <= `PLOS_DLY_ZERO;
      dlyCnt  <= `PLOS_DLY_ZERO;
      edgeCnt <= `PLOS_CNT_ZERO;
      tapPrev <= 1'b0;
      clkOut  <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      // stopped: follow the tap the next run uses, no false first edge
      tapPrev <= (state == `PLOS_ST_STOP) ? taps[phaseSel] : tapNow;
      clkOut  <= next_clkOut;
      // changes seen only while stopped keep restart glitch-free
      if (state == `PLOS_ST_STOP)
      begin
        selHeld <= phaseSel;
        divHeld <= (divRatio == `PLOS_DIV_ZERO) ? `PLOS_DIV_ONE : divRatio;
        dlyHeld <= startDelay;
        dlyCnt  <= `PLOS_DLY_ZERO;
      end
      else if (state == `PLOS_ST_DELAY && quarterTick &&
               dlyCnt != dlyHeld)
        dlyCnt <= dlyCnt + 3'h1;
      if (next_state != `PLOS_ST_RUN)
        edgeCnt <= `PLOS_CNT_ZERO;
      else if (tapRise)
        edgeCnt <= (state != `PLOS_ST_RUN) ? `PLOS_CNT_ZERO :
                   ((edgeCnt == divHeld - `PLOS_DIV_ONE) ?
                    `PLOS_CNT_ZERO : edgeCnt + `PLOS_DIV_ONE);
    end
  end

endmodule
`default_nettype wire

// ==== src/plos_out_stage.v ====
// Purpose: synthesizer output stage, eight taps to four divided outputs
// Assumes: mclk is the vco sampling clock, one tap period is 8 mclk
// Notes: fabric run inputs are synchronised; config ports are mclk-side
`timescale 1ns/1ps
`default_nettype none
`include "plos_defines.vh"

// Function
// - eight phase taps 45 degrees apart come from one vco ring.
// - each of the four outputs picks any tap on its own.
// - an unused output can be held at constant zero.
// - each output has its own divider, ratio 1 through 127.
// - each output release can be delayed 0 to 7 vco/4 cycles.
// - the feedback divider has a 24-bit fractional-n part.
// - all outputs share the single vco base frequency.
// - each output starts and stops glitch-free from map or fabric.
// - ratio and tap changes are taken only while an output is stopped.
module plos_out_stage (
  input  wire                                  mclk,
  input  wire                                  sys_rst,
  input  wire [`PLOS_NUM_OUT*`PLOS_TAP_W-1:0]  phaseSel,
  input  wire [`PLOS_NUM_OUT*`PLOS_DIV_W-1:0]  divRatio,
  input  wire [`PLOS_NUM_OUT*`PLOS_DLY_W-1:0]  startDelay,
  input  wire [`PLOS_NUM_OUT-1:0]              forceZero,
  input  wire [`PLOS_NUM_OUT-1:0]              mapRun,
  input  wire [`PLOS_NUM_OUT-1:0]              fabricRun,
  input  wire [`PLOS_NUM_OUT-1:0]              useFabric,
  input  wire [`PLOS_FBI_W-1:0]                fbIntDiv,
  input  wire [`PLOS_FRAC_W-1:0]               fbFrac,
  output wire [`PLOS_NUM_OUT-1:0]              clkOut,
  output wire [`PLOS_NUM_OUT-1:0]              outRunning,
  output reg  [`PLOS_NUM_TAP-1:0]              vcoTaps,
  output reg                                   fbPulse
);

  reg  [`PLOS_RING_W-1:0]   ring;
  reg  [`PLOS_NUM_OUT-1:0]  fabSync1;
  reg  [`PLOS_NUM_OUT-1:0]  fabSync2;
  reg  [`PLOS_FRAC_W-1:0]   fracAcc;
  reg  [`PLOS_FBI_W-1:0]    fbCnt;
  reg                       fracCarry;
  reg                       quarterTick;
  reg  [`PLOS_NUM_TAP-1:0]  next_vcoTaps;
  wire [`PLOS_NUM_OUT-1:0]  runReq;
  wire [`PLOS_TAP_W-1:0]    ringPhase;
  wire                      vcoWrap;
  wire [`PLOS_FRAC_W:0]     fracSum;
  wire [`PLOS_FBI_W-1:0]    fbTarget;
  integer                   k;

  assign ringPhase = ring[`PLOS_TAP_W-1:0];
  assign vcoWrap   = (ringPhase == `PLOS_TAP_LAST);
  assign runReq    = (useFabric & fabSync2) | (~useFabric & mapRun);

  // tap k is high for the four ring steps starting at step k
  always @*
  begin
    next_vcoTaps = {`PLOS_NUM_TAP{1'b0}};
    for (k = 0; k < `PLOS_NUM_TAP; k = k + 1)
      next_vcoTaps[k] = ((ringPhase - k[`PLOS_TAP_W-1:0]) <
                         `PLOS_HALF_TAP);
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ring        <= {`PLOS_RING_W{1'b0}};
      vcoTaps     <= `PLOS_TAP_RESET;
      quarterTick <= 1'b0;
      fabSync1    <= {`PLOS_NUM_OUT{1'b0}};
      fabSync2    <= {`PLOS_NUM_OUT{1'b0}};
    end
    else
    begin
      ring        <= ring + 5'h01;
      vcoTaps     <= next_vcoTaps;
      quarterTick <= (ring == `PLOS_RING_LAST);
      fabSync1    <= fabricRun;
      fabSync2    <= fabSync1;
    end
  end

  // fractional-n: the carry stretches one feedback period by a vco cycle
  assign fracSum  = {1'b0, fracAcc} + {1'b0, fbFrac};
  assign fbTarget = ((fbIntDiv == `PLOS_FBI_ZERO) ? `PLOS_FBI_ONE :
                     fbIntDiv) - (fracCarry ? `PLOS_FBI_ZERO :
                     `PLOS_FBI_ONE);

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      fracAcc   <= `PLOS_FRAC_ZERO;
      fracCarry <= 1'b0;
      fbCnt     <= `PLOS_FBI_ZERO;
      fbPulse   <= 1'b0;
    end
    else
    begin
      fbPulse <= 1'b0;
      if (vcoWrap)
      begin
        if (fbCnt >= fbTarget)
        begin
          fbCnt     <= `PLOS_FBI_ZERO;
          fbPulse   <= 1'b1;
          fracAcc   <= fracSum[`PLOS_FRAC_W-1:0];
          fracCarry <= fracSum[`PLOS_FRAC_W];
        end
        else
          fbCnt <= fbCnt + `PLOS_FBI_ONE;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PLOS_NUM_OUT; g = g + 1)
    begin : chan
      plos_out_channel u_chan (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .taps        (vcoTaps),
        .quarterTick (quarterTick),
        .phaseSel    (phaseSel[g*`PLOS_TAP_W +: `PLOS_TAP_W]),
        .divRatio    (divRatio[g*`PLOS_DIV_W +: `PLOS_DIV_W]),
        .startDelay  (startDelay[g*`PLOS_DLY_W +: `PLOS_DLY_W]),
        .forceZero   (forceZero[g]),
        .runReq      (runReq[g]),
        .clkOut      (clkOut[g]),
        .running     (outRunning[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ==== testbench/plos_out_stage_monitor.sv ====
// Purpose: port checker for the output stage
// Assumes: one mclk domain, sys_rst synchronous
// Notes: timing checks watch one output each to stay small
`timescale 1ns/1ps
`default_nettype none
module plos_out_stage_monitor (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [11:0] phaseSel,
  input wire logic [27:0] divRatio,
  input wire logic [11:0] startDelay,
  input wire logic [3:0]  forceZero,
  input wire logic [3:0]  mapRun,
  input wire logic [3:0]  fabricRun,
  input wire logic [3:0]  useFabric,
  input wire logic [7:0]  fbIntDiv,
  input wire logic [23:0] fbFrac,
  input wire logic [3:0]  clkOut,
  input wire logic [3:0]  outRunning,
  input wire logic [7:0]  vcoTaps,
  input wire logic        fbPulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [6:0]  rat;
  logic [2:0]  sel;
  logic [10:0] gap;
  logic [7:0]  prevTap;
  logic [11:0] fbGap;
  logic        fbSeen;
  // channel keeps the config it saw last while stopped
  always_ff @(posedge mclk)
  begin
    if (!outRunning[0])
      {rat, sel} <= {divRatio[6:0], phaseSel[2:0]};
    gap <= $rose(clkOut[0]) ? 11'h001 : gap + 11'h001;
    prevTap <= sys_rst ? 8'h00 : vcoTaps;
    fbGap <= fbPulse ? 12'h001 : fbGap + 12'h001;
    fbSeen <= !sys_rst && (fbSeen || fbPulse);
  end
  tap_ring_a: assert property (prevTap != 8'h00 |->
    vcoTaps == {prevTap[6:0], prevTap[7]}) else $error("tap ring wrong");
  tap_select_a: assert property ($rose(clkOut[0]) |->
    $past(vcoTaps[sel]) && !$past(vcoTaps[sel], 2))
    else $error("output not on its tap");
  zero_hold_a: assert property (forceZero[3] [*8] |->
    !clkOut[3] && !outRunning[3]) else $error("forced output moved");
  run_gate_a: assert property ($rose(clkOut[1]) |->
    outRunning[1]) else $error("clock while stopped");
  high_width_a: assert property ($rose(clkOut[2]) |->
    clkOut[2] [*4] ##1 !clkOut[2]) else $error("high phase wrong");
  div_period_a: assert property ($rose(clkOut[0]) &&
    $past(outRunning[0]) |-> gap == rat * 8) else $error("period wrong");
  low_stop_a: assert property ($fell(outRunning[0]) |->
    !clkOut[0] && !$past(clkOut[0])) else $error("stop while high");
  fb_period_a: assert property (fbPulse && fbSeen &&
    fbFrac == 24'h00_0000 && fbIntDiv != 8'h00 |->
    fbGap == fbIntDiv * 8) else $error("feedback period wrong");
  cover property ($fell(outRunning[0]));
  cover property (forceZero[3] [*8]);
  cover property ($rose(outRunning[2]));
endmodule
bind plos_out_stage plos_out_stage_monitor u_plos_out_stage_monitor (
  .mclk, .sys_rst, .phaseSel, .divRatio, .startDelay, .forceZero, .mapRun,
  .fabricRun, .useFabric, .fbIntDiv, .fbFrac, .clkOut, .outRunning,
  .vcoTaps, .fbPulse);
`default_nettype wire

// ==== testbench/plos_fabric_model.sv ====
// Purpose: fabric logic that raises and drops run requests
// Assumes: fabric timing is unrelated to mclk
// Notes: edges land mid cycle so the synchroniser is exercised
`timescale 1ns/1ps
`default_nettype none
module plos_fabric_model (
  input  wire logic [3:0] want,
  output var  logic [3:0] fabricRun
);
  initial fabricRun = 4'h0;
  always @(want) fabricRun <= #7 want;
endmodule
`default_nettype wire

// ==== testbench/plos_out_stage_bench.sv ====
// Purpose: directed bench for the output stage
// Assumes: inputs move on the falling edge of mclk
// Notes: delay bounds allow for the unknown vco/4 phase
`timescale 1ns/1ps
`default_nettype none
module plos_out_stage_bench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] phaseSel = 12'h01D5;
  logic [27:0] divRatio = {7'h02, 7'h7F, 7'h03, 7'h01};
  logic [11:0] startDelay = {3'h0, 3'h7, 3'h0, 3'h0};
  logic [3:0]  forceZero = 4'h0, mapRun = 4'h0, want = 4'h0;
  logic [3:0]  useFabric = 4'h2;
  logic [7:0]  fbIntDiv = 8'h03;
  logic [23:0] fbFrac = 24'h00_0000;
  wire  [3:0]  fabricRun, clkOut, outRunning;
  wire  [7:0]  vcoTaps;
  wire         fbPulse;
  int          num_errors = 0, comparisons = 0, cycles = 0, n;
  plos_fabric_model u_plos_fabric_model (.want, .fabricRun);
  plos_out_stage u_plos_out_stage (.mclk, .sys_rst, .phaseSel, .divRatio,
    .startDelay, .forceZero, .mapRun, .fabricRun, .useFabric, .fbIntDiv,
    .fbFrac, .clkOut, .outRunning, .vcoTaps, .fbPulse);
  initial forever #10 mclk = ~mclk;
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic lat(input int g);
    n = 0;
    while (outRunning[g] !== 1'b1)
    begin
      n++;
      cyc(1);
    end
  endtask
  // fall to fall, so the width of the first pulse does not matter
  task automatic per(input int g);
    while (clkOut[g] !== 1'b1) cyc(1);
    while (clkOut[g] === 1'b1) cyc(1);
    n = 0;
    while (clkOut[g] !== 1'b1)
    begin
      n++;
      cyc(1);
    end
    while (clkOut[g] === 1'b1)
    begin
      n++;
      cyc(1);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    cyc(6);
    sys_rst = 1'b0;
    check("idle", {clkOut, outRunning, vcoTaps, fbPulse},
      {4'h0, 4'h0, 8'hF0, 1'b0});
    mapRun = 4'h9;
    lat(0);
    check("delay0", n >= 1 && n <= 10, 1);
    mapRun[2] = 1'b1;
    lat(2);
    check("delay7", n >= 192 && n <= 256, 1);
    want[1] = 1'b1;
    cyc(20);
    check("fabric", outRunning[1], 1);
    divRatio[6:0] = 7'h05;
    per(0);
    check("held", n, 8);
    mapRun[0] = 1'b0;
    cyc(12);
    check("stop", outRunning[0], 0);
    mapRun[0] = 1'b1;
    lat(0);
    per(0);
    check("ratio5", n, 40);
    per(2);
    check("ratio127", n, 1016);
    forceZero[3] = 1'b1;
    cyc(40);
    check("zero", {clkOut[3], outRunning[3]}, 0);
    mapRun = 4'h0;
    want = 4'h0;
    cyc(20);
    check("all stop", {clkOut, outRunning}, 0);
    for (int k = 0; k < 2; k++)
    begin
      fbIntDiv = k ? 8'h02 : 8'h03;
      fbFrac = k ? 24'h80_0000 : 24'h00_0000;
      cyc(60);
      n = 0;
      repeat (960)
      begin
        cyc(1);
        n += (fbPulse === 1'b1);
      end
      check("fbPulse", n >= 39 + 8 * k && n <= 41 + 8 * k, 1);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
